// ---- rtl/otw_overtravel.sv ----
// overtravel supervision: stop, warning, status and direction blocking
`timescale 1ns/1ns
`include "otw_params.svh"

// Function
// R1: stop method setting picks stopping behaviour
// R2: limit input off means overtravel that direction
// R3: torque decel uses emergency stop torque
// R4: stop torque 0..800 percent, default 800
// R5: decel time 0..10000 ms, default zero
// R6: zero decel time gives immediate zero speed
// R7: warning on servo-on overtravel, even momentary
// R8: no warning while servo is off
// R9: warning never stops motor or commands
// R10: warning enable digit switches detection immediately
// R11: warn only for limit matching reference direction
// R12: no reference warns on either limit
// R13: no warning at servo-on with existing overtravel
// R14: clear command clears warning always; a new overtravel edge in the same cycle sets it again
// R15: fault reset suppresses until overtravel left; a fault reset while softLimitActive is high sets no suppression
// R16: release setting, after restart, adds position test
// R17: block drive toward active limit only
// R18: status bit 11 and input bits 0,1
// R19: position modes cancel, clear target reached
// R20: forward limit fails listed homing methods
// R21: reverse limit fails listed homing methods
// R22: velocity runs only away from limit
// R23: torque applies only away from limit
// R24: host checks feedback position after warning
module otw_overtravel #(
	parameter int DECEL_W = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             clkEn,
	input  wire logic             forwardLimitInput,
	input  wire logic             reverseLimitInput,
	input  wire logic             beyondForward,
	input  wire logic             beyondReverse,
	input  wire logic             motorStopped,
	input  wire logic             faultResetCmd,
	input  wire logic             clearAlarmsWarningsCmd,
	input  wire logic             softLimitActive,
	input  wire otw_pkg::otw_ref_t refIn,
	input  wire otw_pkg::otw_wr_t  wrIn,
	input  wire logic [15:0]      rdAddr,
	output logic [31:0]           rdData,
	output logic                  driveEnable,
	output logic                  stopActive,
	output otw_pkg::otw_stop_t    stopKind,
	output logic [15:0]           stopTorqueLimit,
	output logic                  cancelMotion,
	output logic                  warningActive,
	output logic [15:0]           warningCode
);
	typedef struct packed {
		logic [15:0]          warnEn;
		logic [15:0]          releaseSel;
		logic [15:0]          decelTime;
		logic [15:0]          estopTrq;
		logic [15:0]          stopMethod;
		logic                 releaseLatched;
		logic                 releaseCaught;
		logic [7:0]           stopMethodLatched;
		otw_pkg::otw_state_t  state;
		logic                 fwdOt;
		logic                 revOt;
		logic                 servoOnD;
		logic                 warn;
		logic                 suppress;
		logic                 homeErr;
		logic                 tgtReached;
		logic [31:0]          rdData;
		logic                 driveEnable;
		logic                 stopActive;
		otw_pkg::otw_stop_t   stopKind;
		logic [15:0]          stopTorqueLimit;
		logic                 cancelMotion;
		logic [15:0]          warningCode;
	} otw_st_t;

	otw_st_t st_r;
	otw_st_t st_nxt;

	// homing methods that fail on the forward limit
	function automatic logic homeFwdFail(input logic [7:0] m);
		return m inside {8'h01, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h1c,
			8'h22};
	endfunction

	// homing methods that fail on the reverse limit
	function automatic logic homeRevFail(input logic [7:0] m);
		return m inside {8'h02, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h18,
			8'h21};
	endfunction

	// clamp a written value to its legal maximum
	function automatic logic [15:0] clampVal(input logic [15:0] v,
		input logic [15:0] mx);
		return (v > mx) ? mx : v;
	endfunction

	// decode the latched stop method digit
	function automatic otw_pkg::otw_stop_t stopDecode(
		input logic [7:0] m, input logic [15:0] t);
		otw_pkg::otw_stop_t k;
		k = otw_pkg::STOP_DYN_BRAKE;
		unique case (m[7:4])
			4'h1, 4'h2: k = otw_pkg::STOP_TORQUE;
			4'h3, 4'h4: k = (t == 16'h0000) ? otw_pkg::STOP_ZERO_SPEED
				: otw_pkg::STOP_DECEL_TIME;
			default: k = (m[3:0] == 4'h0) ? otw_pkg::STOP_DYN_BRAKE
				: otw_pkg::STOP_COAST;
		endcase
		return k;
	endfunction

	logic fwdRaw;
	logic revRaw;
	logic fwdOt;
	logic revOt;
	logic anyOt;
	logic towardLimit;

	// combined overtravel view; release mode latched at restart
	always_comb
	begin
		fwdRaw = !forwardLimitInput; // R2
		revRaw = !reverseLimitInput; // R2
		fwdOt = fwdRaw && (!st_r.releaseLatched || beyondForward); // R16
		revOt = revRaw && (!st_r.releaseLatched || beyondReverse); // R16
		anyOt = fwdOt || revOt;
		towardLimit = refIn.refValid &&
			((fwdOt && !refIn.refNeg) || (revOt && refIn.refNeg)); // R17
	end

	// next state of the whole block
	always_comb
	begin
		st_nxt = st_r;
		if (wrIn.wrEn)
		begin
			unique case (wrIn.addr)
				`OTW_OFS_WARN_EN:     st_nxt.warnEn = wrIn.data; // R10
				`OTW_OFS_RELEASE:     st_nxt.releaseSel = wrIn.data; // R16
				`OTW_OFS_DECEL_TIME:  st_nxt.decelTime =
					clampVal(wrIn.data, `OTW_MAX_DECEL_TIME); // R5
				`OTW_OFS_ESTOP_TRQ:   st_nxt.estopTrq =
					clampVal(wrIn.data, `OTW_MAX_ESTOP_TRQ); // R4
				`OTW_OFS_STOP_METHOD: st_nxt.stopMethod = wrIn.data;
				default: ;
			endcase
		end
		// restart-effective settings follow writes until the first
		// servo-on after reset, then hold until the next reset; reset
		// clears the registers, so a one-shot catch would only ever
		// see the reset value
		if (!st_r.releaseCaught)
		begin
			st_nxt.releaseCaught = refIn.servoOn;
			st_nxt.releaseLatched = st_nxt.releaseSel[0]; // R16
			st_nxt.stopMethodLatched = st_nxt.stopMethod[7:0]; // R1
		end
		st_nxt.fwdOt = fwdOt;
		st_nxt.revOt = revOt;
		st_nxt.servoOnD = refIn.servoOn;

		// stop sequencing: the warning never enters here
		unique case (st_r.state)
			otw_pkg::ST_RUN:
				if (towardLimit && refIn.servoOn)
					st_nxt.state = otw_pkg::ST_STOPPING;
			otw_pkg::ST_STOPPING:
				if (!towardLimit)
					st_nxt.state = otw_pkg::ST_RUN;
				else if (motorStopped)
					st_nxt.state = otw_pkg::ST_STOPPED;
			otw_pkg::ST_STOPPED:
				if (!towardLimit)
					st_nxt.state = otw_pkg::ST_RUN;
		endcase
		st_nxt.stopKind = stopDecode(st_r.stopMethodLatched,
			st_r.decelTime); // R1 R6
		st_nxt.stopTorqueLimit = st_r.estopTrq; // R3
		st_nxt.stopActive = towardLimit && refIn.servoOn;

		// direction gating per operating mode
		st_nxt.driveEnable = refIn.servoOn && !towardLimit; // R17 R22 R23
		st_nxt.cancelMotion = 1'b0;
		if (refIn.mode == otw_pkg::MODE_POSITION && towardLimit)
			st_nxt.cancelMotion = 1'b1; // R19
		if (refIn.mode == otw_pkg::MODE_POSITION && motorStopped &&
			st_r.state != otw_pkg::ST_RUN)
			st_nxt.tgtReached = 1'b0; // R19
		else if (refIn.mode == otw_pkg::MODE_POSITION && !anyOt &&
			motorStopped)
			st_nxt.tgtReached = 1'b1;
		if (refIn.mode == otw_pkg::MODE_HOMING)
		begin
			if ((fwdRaw && homeFwdFail(refIn.homingMethod)) ||
				(revRaw && homeRevFail(refIn.homingMethod)))
			begin
				st_nxt.homeErr = 1'b1; // R20 R21
				st_nxt.cancelMotion = 1'b1; // R20 R21
			end
		end
		else
			st_nxt.homeErr = 1'b0;

		// warning detection; new edge at servo-on does not count
		if (!anyOt)
			st_nxt.suppress = 1'b0; // R15
		if (clearAlarmsWarningsCmd || faultResetCmd)
		begin
			st_nxt.warn = 1'b0; // R14
			if (faultResetCmd && anyOt && !softLimitActive)
				st_nxt.suppress = 1'b1; // R15
		end
		if (st_r.warnEn[`OTW_WARN_EN_BIT] && refIn.servoOn &&
			st_r.servoOnD && !st_nxt.suppress) // R8 R10 R13
		begin
			if ((fwdOt && !st_r.fwdOt && (!refIn.refValid ||
				!refIn.refNeg)) || (revOt && !st_r.revOt &&
				(!refIn.refValid || refIn.refNeg)))
				st_nxt.warn = 1'b1; // R7 R11 R12
		end
		st_nxt.warningCode = st_nxt.warn ? `OTW_WARN_CODE : 16'h0000; // R9

		// register readback
		unique case (rdAddr)
			`OTW_OFS_WARN_EN:     st_nxt.rdData = {16'h0000, st_r.warnEn};
			`OTW_OFS_RELEASE:     st_nxt.rdData = {16'h0000, st_r.releaseSel};
			`OTW_OFS_DECEL_TIME:  st_nxt.rdData = {16'h0000,
				st_r.decelTime};
			`OTW_OFS_ESTOP_TRQ:   st_nxt.rdData = {16'h0000, st_r.estopTrq};
			`OTW_OFS_STOP_METHOD: st_nxt.rdData = {16'h0000,
				st_r.stopMethod};
			`OTW_OFS_STATUS:
			begin
				st_nxt.rdData = 32'h0000_0000;
				st_nxt.rdData[`OTW_BIT_INT_LIMIT] = anyOt; // R18
				st_nxt.rdData[`OTW_BIT_HOME_ERR] = st_r.homeErr;
				st_nxt.rdData[`OTW_BIT_TGT_REACHED] = st_r.tgtReached;
			end
			`OTW_OFS_DIGIN:
			begin
				st_nxt.rdData = 32'h0000_0000;
				st_nxt.rdData[`OTW_BIT_NEG_LIMIT] = revOt; // R18
				st_nxt.rdData[`OTW_BIT_POS_LIMIT] = fwdOt; // R18
			end
			default: st_nxt.rdData = 32'h0000_0000;
		endcase
	end

	// single state register with clock enable
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
			st_r.decelTime <= `OTW_RST_DECEL_TIME;
			st_r.estopTrq <= `OTW_RST_ESTOP_TRQ;
			st_r.state <= otw_pkg::ST_RUN;
		end
		else if (clkEn)
			st_r <= st_nxt;
	end

	assign rdData = st_r.rdData;
	assign driveEnable = st_r.driveEnable;
	assign stopActive = st_r.stopActive;
	assign stopKind = st_r.stopKind;
	assign stopTorqueLimit = st_r.stopTorqueLimit;
	assign cancelMotion = st_r.cancelMotion;
	assign warningActive = st_r.warn;
	assign warningCode = st_r.warningCode;

	// drive stays blocked while heading into a limit
	property p_block;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && towardLimit) |=> !driveEnable;
	endproperty
	a_block: assert property (p_block) else $error("drive into limit"); // R17

	// no warning raised with servo off
	property p_nowarnoff;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && !refIn.servoOn && !st_r.warn) |=> !warningActive;
	endproperty
	a_nowarnoff: assert property (p_nowarnoff) else $error("warn off"); // R8

	// clear command drops warning
	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && clearAlarmsWarningsCmd && !refIn.servoOn) |=>
			!warningActive;
	endproperty
	a_clear: assert property (p_clear) else $error("warning not cleared"); // R14

	// warning does not block the drive
	property p_info;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && st_r.warn && refIn.servoOn && !towardLimit) |=>
			(driveEnable && !stopActive);
	endproperty
	a_info: assert property (p_info) else $error("drive blocked"); // R9

	// torque limit tracks estop setting
	property p_trq;
		@(posedge clk) disable iff (!rst_n)
		clkEn |=> stopTorqueLimit == $past(st_r.estopTrq);
	endproperty
	a_trq: assert property (p_trq) else $error("torque limit"); // R3

	// decel time never exceeds range
	property p_range;
		@(posedge clk) disable iff (!rst_n)
		st_r.decelTime <= `OTW_MAX_DECEL_TIME &&
			st_r.estopTrq <= `OTW_MAX_ESTOP_TRQ;
	endproperty
	a_range: assert property (p_range) else $error("setting range"); // R5

	// disabled detection raises nothing new
	property p_disabled;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && !st_r.warnEn[`OTW_WARN_EN_BIT] && !st_r.warn) |=>
			!warningActive;
	endproperty
	a_disabled: assert property (p_disabled) else $error("warn off"); // R10

	// homing failure on forward limit
	property p_home;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && refIn.mode == otw_pkg::MODE_HOMING && fwdRaw &&
			homeFwdFail(refIn.homingMethod)) |=> cancelMotion;
	endproperty
	a_home: assert property (p_home) else $error("homing not cancelled"); // R20

	// homing failure on reverse limit
	property p_homerev;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && refIn.mode == otw_pkg::MODE_HOMING && revRaw &&
			homeRevFail(refIn.homingMethod)) |=> cancelMotion;
	endproperty
	a_homerev: assert property (p_homerev) else $error("homing kept"); // R21

	// position move heading into an active limit
	sequence s_posInto;
		clkEn && refIn.mode == otw_pkg::MODE_POSITION && towardLimit;
	endsequence

	// position mode drops a move heading into an active limit
	property p_poscancel;
		@(posedge clk) disable iff (!rst_n)
		s_posInto |=> cancelMotion;
	endproperty
	a_poscancel: assert property (p_poscancel) else $error("move kept"); // R19

	// timed stop selected with a zero time
	sequence s_zeroTime;
		clkEn && st_r.decelTime == 16'h0000 &&
			st_r.stopMethodLatched[7:4] inside {4'h3, 4'h4};
	endsequence

	// zero time means an immediate zero speed command
	property p_zero;
		@(posedge clk) disable iff (!rst_n)
		s_zeroTime |=> stopKind == otw_pkg::STOP_ZERO_SPEED;
	endproperty
	a_zero: assert property (p_zero) else $error("no zero speed"); // R6

	// servo just switched on with nothing pending
	sequence s_servoRise;
		clkEn && refIn.servoOn && !st_r.servoOnD && !st_r.warn;
	endsequence

	// an overtravel already present at servo-on stays silent
	property p_onquiet;
		@(posedge clk) disable iff (!rst_n)
		s_servoRise |=> !warningActive;
	endproperty
	a_onquiet: assert property (p_onquiet) else $error("servo on warn"); // R13
endmodule

// ---- rtl/otw_params.svh ----
// constants for the overtravel supervision block
`ifndef OTW_PARAMS_SVH
`define OTW_PARAMS_SVH
`define OTW_OFS_WARN_EN     16'h200d
`define OTW_OFS_RELEASE     16'h2022
`define OTW_OFS_DECEL_TIME  16'h230a
`define OTW_OFS_ESTOP_TRQ   16'h2406
`define OTW_OFS_STOP_METHOD 16'h2001
`define OTW_OFS_STATUS      16'h6041
`define OTW_OFS_DIGIN       16'h60fd
`define OTW_RST_DECEL_TIME  16'h0000
`define OTW_RST_ESTOP_TRQ   16'h0320
`define OTW_MAX_DECEL_TIME  16'h2710
`define OTW_MAX_ESTOP_TRQ   16'h0320
`define OTW_BIT_INT_LIMIT   11
`define OTW_BIT_HOME_ERR    13
`define OTW_BIT_TGT_REACHED 10
`define OTW_BIT_NEG_LIMIT   0
`define OTW_BIT_POS_LIMIT   1
`define OTW_WARN_EN_BIT     12
`define OTW_WARN_CODE       16'h09a0
`define OTW_MS_NS           1000000
`define OTW_CLK_NS          10
`define OTW_MS_CYCLES       (`OTW_MS_NS / `OTW_CLK_NS)
`endif

// ---- rtl/otw_pkg.sv ----
// types for the overtravel supervision block
package otw_pkg;
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_POSITION,
		MODE_HOMING,
		MODE_VELOCITY,
		MODE_TORQUE
	} otw_mode_t;

	typedef enum logic [2:0] {
		STOP_DYN_BRAKE,
		STOP_COAST,
		STOP_TORQUE,
		STOP_DECEL_TIME,
		STOP_ZERO_SPEED
	} otw_stop_t;

	typedef enum {
		ST_RUN,
		ST_STOPPING,
		ST_STOPPED
	} otw_state_t;

	// host motion reference bundle
	typedef struct packed {
		otw_mode_t   mode;
		logic        refValid;
		logic        refNeg;
		logic [7:0]  homingMethod;
		logic        servoOn;
	} otw_ref_t;

	// register write port
	typedef struct packed {
		logic        wrEn;
		logic [15:0] addr;
		logic [15:0] data;
	} otw_wr_t;
endpackage

// ---- tb/otw_motor_model.sv ----
// motor standstill model for the far side of the drive
`timescale 1ns/1ns
module otw_motor_model #(
	parameter int STOP_CYC = 3
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic stopActive,
	output logic      motorStopped
);
	logic [7:0] stopCnt_r;

	// spin-down takes a few cycles, not zero, so stop logic sees real delay
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			stopCnt_r <= 8'h00;
		else if (!stopActive)
			stopCnt_r <= 8'h00;
		else if (stopCnt_r < 8'(STOP_CYC))
			stopCnt_r <= stopCnt_r + 8'h01;
	end

	// standstill flag feeds motorStopped of the stop sequencing and target-reached logic
	assign motorStopped = (stopCnt_r == 8'(STOP_CYC));
endmodule

// ---- tb/overtravel_stop_and_warning_test.sv ----
// self-checking bench for the overtravel supervision block
`timescale 1ns/1ns
`include "otw_params.svh"
module overtravel_stop_and_warning_test;
	logic               clk;
	logic               rst_n;
	logic               fwdLim;
	logic               revLim;
	logic               stopped;
	logic               faultRst;
	logic               clrCmd;
	logic               clkEn;
	logic               beyondFwd;
	logic               softLim;
	otw_pkg::otw_ref_t  refIn;
	otw_pkg::otw_wr_t   wrIn;
	logic [15:0]        rdAddr;
	logic [31:0]        rdData;
	logic               driveEnable;
	logic               stopActive;
	otw_pkg::otw_stop_t stopKind;
	logic [15:0]        stopTorqueLimit;
	logic               cancelMotion;
	logic               warningActive;
	logic [15:0]        warningCode;
	int                 num_errors;
	int                 checks;
	logic [31:0]        d;
	logic [6:0]         r;
	// fwd, rev, servo, refValid, refNeg, warnEn, expected warning
	logic [6:0]         rows [7] = '{7'h3b, 7'h5a, 7'h5f, 7'h33,
		7'h53, 7'h2a, 7'h38};

	otw_overtravel i_otw_overtravel (
		.clk                    (clk),
		.rst_n                  (rst_n),
		.clkEn                  (clkEn),
		.forwardLimitInput      (fwdLim),
		.reverseLimitInput      (revLim),
		.beyondForward          (beyondFwd),
		.beyondReverse          (1'b0),
		.motorStopped           (stopped),
		.faultResetCmd          (faultRst),
		.clearAlarmsWarningsCmd (clrCmd),
		.softLimitActive        (softLim),
		.refIn                  (refIn),
		.wrIn                   (wrIn),
		.rdAddr                 (rdAddr),
		.rdData                 (rdData),
		.driveEnable            (driveEnable),
		.stopActive             (stopActive),
		.stopKind               (stopKind),
		.stopTorqueLimit        (stopTorqueLimit),
		.cancelMotion           (cancelMotion),
		.warningActive          (warningActive),
		.warningCode            (warningCode)
	);

	otw_motor_model i_otw_motor_model (
		.clk          (clk),
		.rst_n        (rst_n),
		.stopActive   (stopActive),
		.motorStopped (stopped)
	);

	// clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// inputs always move 1 ns after the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		wrIn = '{1'b1, a, v};
		cyc(1);
		wrIn.wrEn = 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		rdAddr = a;
		cyc(1);
		d = rdData;
	endtask

	task automatic clr();
		clrCmd = 1'b1;
		cyc(1);
		clrCmd = 1'b0;
		cyc(1);
	endtask

	task automatic give_verdict();
		$display("errors %0d comparisons %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog, far beyond the hundred-odd cycles the tests need
	initial
	begin
		#100000;
		num_errors++;
		give_verdict();
	end

	initial
	begin
		num_errors = 0;
		checks = 0;
		rst_n = 1'b0;
		fwdLim = 1'b1;
		revLim = 1'b1;
		faultRst = 1'b0;
		clrCmd = 1'b0;
		refIn = '0;
		clkEn = 1'b1;
		beyondFwd = 1'b0;
		softLim = 1'b0;
		wrIn = '0;
		rdAddr = 16'h0000;
		refIn.mode = otw_pkg::MODE_VELOCITY;
		cyc(4);
		rst_n = 1'b1;
		cyc(2);
		// reset values, clamps, unmapped address
		rd(`OTW_OFS_DECEL_TIME);
		chk(d, 32'h0000_0000);
		rd(`OTW_OFS_ESTOP_TRQ);
		chk(d, 32'h0000_0320);
		wr(`OTW_OFS_ESTOP_TRQ, 16'h0321);
		rd(`OTW_OFS_ESTOP_TRQ);
		chk(d, 32'h0000_0320);
		wr(`OTW_OFS_DECEL_TIME, 16'h2711);
		rd(`OTW_OFS_DECEL_TIME);
		chk(d, 32'h0000_2710);
		rd(16'h1234);
		chk(d, 32'h0000_0000);
		// table of warning cases
		for (int i = 0; i < 7; i++)
		begin
			r = rows[i];
			fwdLim = 1'b1;
			revLim = 1'b1;
			refIn.servoOn = r[4];
			refIn.refValid = r[3];
			refIn.refNeg = r[2];
			wr(`OTW_OFS_WARN_EN, {3'h0, r[1], 12'h000});
			clr();
			fwdLim = r[6];
			revLim = r[5];
			cyc(2);
			chk(32'(warningActive), 32'(r[0]));
			rd(`OTW_OFS_DIGIN);
			chk(32'(d[1:0]), 32'({~r[6], ~r[5]}));
		end
		// servo switched on into an existing overtravel
		fwdLim = 1'b1;
		revLim = 1'b1;
		refIn.servoOn = 1'b0;
		wr(`OTW_OFS_WARN_EN, 16'h1000);
		clr();
		fwdLim = 1'b0;
		cyc(2);
		refIn.servoOn = 1'b1;
		refIn.refValid = 1'b1;
		cyc(3);
		chk(32'(warningActive), 32'h0);
		chk(32'(driveEnable), 32'h0);
		rd(`OTW_OFS_STATUS);
		chk(32'(d[11]), 32'h1);
		refIn.refNeg = 1'b1;
		cyc(2);
		chk(32'(driveEnable), 32'h1);
		// fault reset during overtravel holds off re-detection
		fwdLim = 1'b1;
		refIn.refValid = 1'b0;
		cyc(2);
		fwdLim = 1'b0;
		cyc(2);
		chk(32'(warningActive), 32'h1);
		chk(32'(warningCode), 32'h09a0);
		faultRst = 1'b1;
		cyc(1);
		faultRst = 1'b0;
		revLim = 1'b0;
		cyc(2);
		chk(32'(warningActive), 32'h0);
		fwdLim = 1'b1;
		revLim = 1'b1;
		cyc(2);
		fwdLim = 1'b0;
		cyc(2);
		chk(32'(warningActive), 32'h1);
		// with a software limit the fault reset does not hold off
		softLim = 1'b1;
		faultRst = 1'b1;
		cyc(1);
		faultRst = 1'b0;
		revLim = 1'b0;
		cyc(2);
		chk(32'(warningActive), 32'h1);
		softLim = 1'b0;
		revLim = 1'b1;
		// warning does not block motion away from the limit
		refIn.refValid = 1'b1;
		cyc(2);
		chk(32'(driveEnable), 32'h1);
		refIn.servoOn = 1'b0;
		clr();
		chk(32'(warningActive), 32'h0);
		// homing error on a listed method
		fwdLim = 1'b1;
		refIn.servoOn = 1'b1;
		refIn.mode = otw_pkg::MODE_HOMING;
		refIn.homingMethod = 8'h01;
		cyc(2);
		fwdLim = 1'b0;
		cyc(2);
		rd(`OTW_OFS_STATUS);
		chk(32'(d[13]), 32'h1);
		chk(32'(cancelMotion), 32'h1);
		// reverse limit fails the reverse homing methods
		fwdLim = 1'b1;
		revLim = 1'b0;
		refIn.homingMethod = 8'h02;
		cyc(2);
		chk(32'(cancelMotion), 32'h1);
		// position move into the limit is dropped, away is allowed
		revLim = 1'b1;
		fwdLim = 1'b0;
		refIn.mode = otw_pkg::MODE_POSITION;
		refIn.refValid = 1'b1;
		refIn.refNeg = 1'b0;
		cyc(2);
		chk(32'(cancelMotion), 32'h1);
		chk(32'(stopActive), 32'h1);
		chk(32'(stopKind), 32'(otw_pkg::STOP_DYN_BRAKE));
		chk(32'(stopTorqueLimit), 32'h0320);
		refIn.refNeg = 1'b1;
		cyc(2);
		chk(32'(cancelMotion), 32'h0);
		// low clock enable freezes the outputs
		clkEn = 1'b0;
		refIn.refNeg = 1'b0;
		cyc(2);
		chk(32'(driveEnable), 32'h1);
		clkEn = 1'b1;
		cyc(2);
		chk(32'(driveEnable), 32'h0);
		// restart: release needs position past the limit, timed stop
		rst_n = 1'b0;
		refIn.servoOn = 1'b0;
		refIn.mode = otw_pkg::MODE_VELOCITY;
		fwdLim = 1'b1;
		cyc(2);
		chk(32'(warningActive), 32'h0);
		rst_n = 1'b1;
		cyc(1);
		wr(`OTW_OFS_RELEASE, 16'h0001);
		cyc(1);
		wr(`OTW_OFS_STOP_METHOD, 16'h0030);
		refIn.servoOn = 1'b1;
		fwdLim = 1'b0;
		cyc(2);
		chk(32'(stopKind), 32'(otw_pkg::STOP_ZERO_SPEED));
		rd(`OTW_OFS_DIGIN);
		chk(32'(d[1]), 32'h0);
		beyondFwd = 1'b1;
		cyc(2);
		chk(32'(stopActive), 32'h1);
		rd(`OTW_OFS_DIGIN);
		chk(32'(d[1]), 32'h1);
		wr(`OTW_OFS_DECEL_TIME, 16'h0064);
		cyc(1);
		wr(`OTW_OFS_STOP_METHOD, 16'h0010);
		cyc(2);
		chk(32'(stopKind), 32'(otw_pkg::STOP_DECEL_TIME));
		// a second restart brings in the torque stop
		refIn.servoOn = 1'b0;
		rst_n = 1'b0;
		cyc(1);
		rst_n = 1'b1;
		wr(`OTW_OFS_STOP_METHOD, 16'h0010);
		refIn.servoOn = 1'b1;
		cyc(2);
		chk(32'(stopKind), 32'(otw_pkg::STOP_TORQUE));
		chk(32'(stopTorqueLimit), 32'h0320);
		chk(32'(stopActive), 32'h1);
		give_verdict();
	end
endmodule
